/* File: rtl/switch_matrix_consts.vh */
// Constants for the switch matrix control register bank
// Function
// - Config bit 16 picks individual registers (1) or group decode fields (0).
// - Individual register writes affect switches only once the select bit is set.
// - Four read-only status registers report each switch open or closed.
// - Config bit 18 drives the second auxiliary TIA switch; resets to zero.
// - Config bit 17 drives the first auxiliary TIA switch; resets to zero.
// - TIA group code decodes to single switch, calibration, all closed or all open.
// - Negative group code decodes LDO tie, singles, calibration, alternate tie or open.
// - Positive group code decodes LDO tie, calibration, singles, alternate tie or open.
// - Output group code decodes to single switch, calibration, all closed or open.
// - Config register resets to 0x0000FFFF, all group codes at 0xF.
// - Four individual registers are read/write, reset zero, stored regardless of source.
// - Every switch is open after power-up.
// - In individual registers, bit one closes its switch, zero opens it, except TIA bits 9 and 10, which follow config bits 17 and 18.
`ifndef SWITCH_MATRIX_CONSTS_VH
`define SWITCH_MATRIX_CONSTS_VH
`define SM_ADDR_CONFIG     14'h200C
`define SM_ADDR_EXC_IND    14'h2150
`define SM_ADDR_NEG_IND    14'h2154
`define SM_ADDR_POS_IND    14'h2158
`define SM_ADDR_TIA_IND    14'h215C
`define SM_ADDR_EXC_STA    14'h21B0
`define SM_ADDR_POS_STA    14'h21B4
`define SM_ADDR_NEG_STA    14'h21B8
`define SM_ADDR_TIA_STA    14'h21BC
`define SM_CONFIG_RESET    19'h0FFFF
`define SM_CONFIG_MASK     32'h0007FFFF
`define SM_IND_MASK        32'h0000FFFF
`define SM_BIT_SELECT      16
`define SM_BIT_AUX_A       17
`define SM_BIT_AUX_B       18
`define SM_TIA_LSB         12
`define SM_NEG_LSB         8
`define SM_POS_LSB         4
`define SM_EXC_LSB         0
`define SM_TIA_CAL_BIT     8
`define SM_TIA_AUX_A_BIT   9
`define SM_TIA_AUX_B_BIT   10
`define SM_NEG_CAL_BIT     9
`define SM_NEG_LDO_BIT     10
`define SM_NEG_LDO2_BIT    11
`define SM_POS_CAL_BIT     0
`define SM_POS_LDO_BIT     14
`define SM_POS_LDO2_BIT    15
`define SM_EXC_CAL_BIT     0
`define SM_RESP_OKAY       2'h0
`define SM_RESP_SLVERR     2'h2
`endif

/* File: rtl/switch_matrix_control.v */
// AXI4-Lite register bank driving the analog switch matrix
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "switch_matrix_consts.vh"
module switch_matrix_control #(
    parameter ADDR_W = 14
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              clk_en,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg  [15:0]       exc_output_switches,
    output reg  [15:0]       pos_node_switches,
    output reg  [15:0]       neg_node_switches,
    output reg  [15:0]       tia_input_switches
);

    reg  [18:0]       config_q;
    reg  [15:0]       exc_ind_q;
    reg  [15:0]       neg_ind_q;
    reg  [15:0]       pos_ind_q;
    reg  [15:0]       tia_ind_q;
    reg  [ADDR_W-1:0] awaddr_q;
    reg  [31:0]       wdata_q;
    reg  [3:0]        wstrb_q;
    reg               aw_held_q;
    reg               w_held_q;
    reg  [15:0]       exc_d;
    reg  [15:0]       pos_d;
    reg  [15:0]       neg_d;
    reg  [15:0]       tia_d;
    wire [31:0]       wmask;
    reg  [31:0]       rdata_d;
    reg               rhit_d;
    reg               whit;
    wire [3:0]        tia_code = config_q[`SM_TIA_LSB+3:`SM_TIA_LSB];
    wire [3:0]        neg_code = config_q[`SM_NEG_LSB+3:`SM_NEG_LSB];
    wire [3:0]        pos_code = config_q[`SM_POS_LSB+3:`SM_POS_LSB];
    wire [3:0]        exc_code = config_q[`SM_EXC_LSB+3:`SM_EXC_LSB];
    wire              do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    genvar            g;

    // Byte-lane enables; a lane whose strobe is low keeps its old bits
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign wmask[g*8 +: 8] = {8{wstrb_q[g]}};
        end
    endgenerate

    // Group decode; codes give one-hot, all-closed or all-open patterns in the individual-register layout
    always @* begin
        exc_d = 16'h0000;
        pos_d = 16'h0000;
        neg_d = 16'h0000;
        tia_d = 16'h0000;
        if (config_q[`SM_BIT_SELECT]) begin
            exc_d = exc_ind_q;
            pos_d = pos_ind_q;
            neg_d = neg_ind_q;
            tia_d = tia_ind_q;
        end else begin
            // Codes above the all-closed code are spares and open every switch
            case (exc_code)
                4'h0: exc_d = 16'h0000;
                4'h1: exc_d[`SM_EXC_CAL_BIT] = 1'b1;
                4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
                    exc_d[exc_code - 4'h1] = 1'b1;
                end
                4'h9: exc_d = 16'h01FF;
                default: exc_d = 16'h0000;
            endcase
            // The auxiliary switches are outside this field
            case (tia_code)
                4'h0: tia_d = 16'h0000;
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                    tia_d[tia_code - 4'h1] = 1'b1;
                end
                4'h8: tia_d[`SM_TIA_CAL_BIT] = 1'b1;
                4'h9: tia_d = 16'h01FF;
                default: tia_d = 16'h0000;
            endcase
            case (neg_code)
                4'h0: neg_d[`SM_NEG_LDO_BIT] = 1'b1;
                4'h8: neg_d = 16'h0000;
                4'h9: neg_d[8] = 1'b1;
                4'hA: neg_d[`SM_NEG_CAL_BIT] = 1'b1;
                4'hB, 4'hC, 4'hD, 4'hE: neg_d[`SM_NEG_LDO2_BIT] = 1'b1;
                4'hF: neg_d = 16'h0000;
                default: neg_d[neg_code - 4'h1] = 1'b1;
            endcase
            case (pos_code)
                4'h0: pos_d[`SM_POS_LDO_BIT] = 1'b1;
                4'h1: pos_d[`SM_POS_CAL_BIT] = 1'b1;
                4'hA, 4'hC, 4'hF: pos_d = 16'h0000;
                4'hB: pos_d[11] = 1'b1;
                4'hD, 4'hE: pos_d[`SM_POS_LDO2_BIT] = 1'b1;
                default: pos_d[pos_code[3:0]] = 1'b1;
            endcase
        end
        // Auxiliary TIA switches follow the config bits in either mode
        tia_d[`SM_TIA_AUX_A_BIT] = config_q[`SM_BIT_AUX_A];
        tia_d[`SM_TIA_AUX_B_BIT] = config_q[`SM_BIT_AUX_B];
    end

    always @* begin
        rhit_d  = 1'b1;
        rdata_d = 32'h00000000;
        case (s_axi_araddr)
            `SM_ADDR_CONFIG:  rdata_d = {13'h0000, config_q};
            `SM_ADDR_EXC_IND: rdata_d = {16'h0000, exc_ind_q};
            `SM_ADDR_NEG_IND: rdata_d = {16'h0000, neg_ind_q};
            `SM_ADDR_POS_IND: rdata_d = {16'h0000, pos_ind_q};
            `SM_ADDR_TIA_IND: rdata_d = {16'h0000, tia_ind_q};
            `SM_ADDR_EXC_STA: rdata_d = {16'h0000, exc_output_switches};
            `SM_ADDR_POS_STA: rdata_d = {16'h0000, pos_node_switches};
            `SM_ADDR_NEG_STA: rdata_d = {16'h0000, neg_node_switches};
            `SM_ADDR_TIA_STA: rdata_d = {16'h0000, tia_input_switches};
            default:          rhit_d  = 1'b0;
        endcase
        case (awaddr_q)
            `SM_ADDR_CONFIG, `SM_ADDR_EXC_IND, `SM_ADDR_NEG_IND,
            `SM_ADDR_POS_IND, `SM_ADDR_TIA_IND: whit = 1'b1;
            default: whit = 1'b0;
        endcase
    end

    // Write channel: address and data latched in either order, one write at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            config_q      <= `SM_CONFIG_RESET;
            exc_ind_q     <= 16'h0000;
            neg_ind_q     <= 16'h0000;
            pos_ind_q     <= 16'h0000;
            tia_ind_q     <= 16'h0000;
            awaddr_q      <= {ADDR_W{1'b0}};
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SM_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q  <= s_axi_awaddr;
                aw_held_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                w_held_q <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= whit ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
                // Stored independently of the selected source
                case (awaddr_q)
                    // Only the 19 defined bits are stored, so reserved bits stay zero
                    `SM_ADDR_CONFIG: config_q <= (config_q & ~wmask[18:0])
                        | (wdata_q[18:0] & wmask[18:0]);
                    `SM_ADDR_EXC_IND: exc_ind_q <= (exc_ind_q & ~wmask[15:0])
                        | (wdata_q[15:0] & wmask[15:0]);
                    `SM_ADDR_NEG_IND: neg_ind_q <= (neg_ind_q & ~wmask[15:0])
                        | (wdata_q[15:0] & wmask[15:0]);
                    `SM_ADDR_POS_IND: pos_ind_q <= (pos_ind_q & ~wmask[15:0])
                        | (wdata_q[15:0] & wmask[15:0]);
                    `SM_ADDR_TIA_IND: tia_ind_q <= (tia_ind_q & ~wmask[15:0])
                        | (wdata_q[15:0] & wmask[15:0]);
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
        end
    end

    // Read channel: one outstanding read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SM_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_d;
                s_axi_rresp  <= rhit_d ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Applied switch state; registered so outputs and status agree cycle for cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            exc_output_switches <= 16'h0000;
            pos_node_switches   <= 16'h0000;
            neg_node_switches   <= 16'h0000;
            tia_input_switches  <= 16'h0000;
        end else if (clk_en) begin
            exc_output_switches <= exc_d;
            pos_node_switches   <= pos_d;
            neg_node_switches   <= neg_d;
            tia_input_switches  <= tia_d;
        end
    end

endmodule

/* File: verification/switch_matrix_control_asserts.sv */
// Bus and switch output checker for the switch matrix register bank
`timescale 1ns/1ps
`include "switch_matrix_consts.vh"
module switch_matrix_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [15:0] exc_output_switches,
    input wire [15:0] pos_node_switches,
    input wire [15:0] neg_node_switches,
    input wire [15:0] tia_input_switches
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire [63:0] sw = {exc_output_switches, pos_node_switches, neg_node_switches,
                      tia_input_switches};
    reset_open_a: assert property (disable iff (1'b0) !aresetn |=> sw == 64'h0)
        else $error("switch closed after reset");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    bresp_code_a: assert property (s_axi_bvalid |->
        s_axi_bresp == `SM_RESP_OKAY || s_axi_bresp == `SM_RESP_SLVERR)
        else $error("bad write response code");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `SM_RESP_SLVERR |->
        s_axi_rdata == 32'h0) else $error("refused read not zero");
    switch_cause_a: assert property (!$stable(sw) |-> $past(s_axi_bvalid))
        else $error("switch moved without a write");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_rvalid && s_axi_rresp == `SM_RESP_SLVERR);
endmodule
bind switch_matrix_control switch_matrix_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .exc_output_switches(exc_output_switches), .pos_node_switches(pos_node_switches),
    .neg_node_switches(neg_node_switches), .tia_input_switches(tia_input_switches));

/* File: verification/tb_top.sv */
// Register level testbench for the switch matrix register bank
`timescale 1ns/1ps
`include "switch_matrix_consts.vh"
module tb_top;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        en = 1;
    logic [13:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  br, rr;
    logic        awr, wr_r, bv, arr, rv;
    logic [15:0] exc, pos, neg, tia;
    int          n_fail = 0, tests_run = 0, cyc = 0, i;
    logic [63:0] x;
    switch_matrix_control i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(en),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .exc_output_switches(exc), .pos_node_switches(pos),
        .neg_node_switches(neg), .tia_input_switches(tia));
    initial forever #10 aclk = ~aclk;
    task conclude;
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            conclude;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 0;
            if (wr_r === 1'b1) wv <= 0;
        end while (bv !== 1'b1);
        bry <= 0;
        chk("bresp", er, br);
        repeat (2) @(posedge aclk);
    endtask
    task rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= a; arv <= 1; rry <= 1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 0;
        end while (rv !== 1'b1);
        rry <= 0;
        chk("rresp", er, rr);
        chk("rdata", e, rdat);
    endtask
    task outs(input logic [63:0] e);
        chk("exc", e[63:48], exc);
        chk("pos", e[47:32], pos);
        chk("neg", e[31:16], neg);
        chk("tia", e[15:0], tia);
    endtask
    function automatic logic [63:0] dec(input logic [3:0] c);
        logic [15:0] t;
        logic [15:0] e;
        logic [15:0] p;
        logic [15:0] n;
        t = c == 0 ? 16'h0 : c <= 7 ? 16'h1 << (c - 1) : c == 8 ? 16'h0100 :
            c == 9 ? 16'h01FF : 16'h0;
        e = c == 0 ? 16'h0 : c <= 8 ? 16'h1 << (c - 1) : c == 9 ? 16'h01FF : 16'h0;
        p = c == 0 ? 16'h4000 : c == 1 ? 16'h0001 : c <= 9 ? 16'h1 << c :
            c == 11 ? 16'h0800 : (c == 13 || c == 14) ? 16'h8000 : 16'h0;
        n = c == 0 ? 16'h0400 : c <= 7 ? 16'h1 << (c - 1) : c == 9 ? 16'h0100 :
            c == 10 ? 16'h0200 : c <= 14 ? 16'h0800 : 16'h0;
        return {e, p, n, t};
    endfunction
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        outs(64'h0);
        rd(`SM_ADDR_CONFIG, 32'h0000FFFF, `SM_RESP_OKAY);
        // Clock enable low must stall the bus; the read finishes once it returns
        @(posedge aclk);
        en <= 0;
        fork
            rd(`SM_ADDR_CONFIG, 32'h0000FFFF, `SM_RESP_OKAY);
            begin
                repeat (4) @(posedge aclk);
                chk("frozen arready", 32'h0, {31'h0, arr});
                chk("frozen rvalid", 32'h0, {31'h0, rv});
                en <= 1;
            end
        join
        for (i = 0; i < 4; i++) begin
            rd(`SM_ADDR_EXC_IND + 4 * i, 32'h0, `SM_RESP_OKAY);
            rd(`SM_ADDR_EXC_STA + 4 * i, 32'h0, `SM_RESP_OKAY);
        end
        for (i = 0; i < 16; i++) begin
            wr(`SM_ADDR_CONFIG, {16'h0, {4{i[3:0]}}}, `SM_RESP_OKAY);
            x = dec(i[3:0]);
            chk("exc", x[63:48], exc);
            if (i != 10 && i != 12) chk("pos", x[47:32], pos);
            if (i != 8) chk("neg", x[31:16], neg);
            chk("tia", x[15:0], tia);
        end
        // Individual values staged while the group codes still hold every switch open
        wr(`SM_ADDR_EXC_IND, 32'h000000A5, `SM_RESP_OKAY);
        wr(`SM_ADDR_NEG_IND, 32'h000000C3, `SM_RESP_OKAY);
        wr(`SM_ADDR_POS_IND, 32'h00008001, `SM_RESP_OKAY);
        wr(`SM_ADDR_TIA_IND, 32'h00000105, `SM_RESP_OKAY);
        outs(64'h0);
        rd(`SM_ADDR_POS_IND, 32'h00008001, `SM_RESP_OKAY);
        wr(`SM_ADDR_CONFIG, 32'h0005FFFF, `SM_RESP_OKAY);
        outs({16'h00A5, 16'h8001, 16'h00C3, 16'h0505});
        rd(`SM_ADDR_TIA_STA, 32'h00000505, `SM_RESP_OKAY);
        rd(`SM_ADDR_NEG_STA, 32'h000000C3, `SM_RESP_OKAY);
        wr(`SM_ADDR_CONFIG, 32'hFFFFFFFF, `SM_RESP_OKAY);
        rd(`SM_ADDR_CONFIG, 32'h0007FFFF, `SM_RESP_OKAY);
        chk("tia", 32'h0705, tia);
        // Hibernate setting: both tie switches on each excitation node closed
        wr(`SM_ADDR_POS_IND, 32'h0000C000, `SM_RESP_OKAY);
        wr(`SM_ADDR_NEG_IND, 32'h00000C00, `SM_RESP_OKAY);
        outs({16'h00A5, 16'hC000, 16'h0C00, 16'h0705});
        wr(`SM_ADDR_EXC_STA, 32'h0, `SM_RESP_SLVERR);
        rd(`SM_ADDR_EXC_STA, 32'h000000A5, `SM_RESP_OKAY);
        rd(14'h0100, 32'h0, `SM_RESP_SLVERR);
        conclude;
    end
endmodule
